// ### hw/tws_pkg.sv
// shared constants and state types for the two-wire slave link
package tws_pkg;
    // system clock and the two documented bus rates
    localparam int SYS_CLK_HZ    = 10_000_000;
    localparam int RATE_STD_BPS  = 100_000;
    localparam int RATE_FAST_BPS = 400_000;
    // one quarter of a bit period, in system clocks, at the standard rate
    localparam int QUARTER_CYC   = SYS_CLK_HZ / (4 * RATE_STD_BPS);
    localparam int ADDR_W        = 7;
    localparam int BYTE_W        = 8;
    // rising-edge counts inside one byte slot
    localparam logic [3:0] CNT_BYTE  = 4'h8;
    localparam logic [3:0] CNT_ACK   = 4'h9;
    localparam logic       RW_WRITE  = 1'b0;
    // reset values of the status and control bits
    localparam logic STOP_RST    = 1'b1;
    localparam logic RELEASE_RST = 1'b1;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_ADDR = 4'b0010,
        S_DATA = 4'b0100,
        S_SKIP = 4'b1000
    } tws_sstate_t;

    typedef enum logic [3:0] {
        M_IDLE  = 4'b0001,
        M_START = 4'b0010,
        M_BIT   = 4'b0100,
        M_STOP  = 4'b1000
    } tws_mstate_t;
endpackage

// ### hw/tws_if.sv
// open-drain two-wire bus joining the master end and the slave end
`timescale 1ns/1ps
interface tws_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic s_scl_o;
    logic s_scl_oe_n;
    logic s_sda_o;
    logic s_sda_oe_n;
    logic scl;
    logic sda;

    // wired-and with pull-up: a line is low when any end drives a low
    assign scl = ~((~m_scl_oe_n & ~m_scl_o) | (~s_scl_oe_n & ~s_scl_o));
    assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));

    modport master (
        output m_scl_o,
        output m_scl_oe_n,
        output m_sda_o,
        output m_sda_oe_n,
        input  scl,
        input  sda
    );

    modport slave (
        output s_scl_o,
        output s_scl_oe_n,
        output s_sda_o,
        output s_sda_oe_n,
        input  scl,
        input  sda
    );
endinterface

// ### hw/tws_slave.sv
// two-wire slave receive path: address match, ack, flags, clock stretch
// What this block does
// - recognise only seven-bit addresses against own address
// - work at standard and fast bit rates
// - set start-seen flag on start condition
// - compare address byte in hardware automatically
// - set buffer-full after eighth falling edge on match
// - acknowledge matched address and raise interrupt
// - interrupt after ninth falling edge, address and data
// - stop condition raises no interrupt
// - software reads data register after every interrupt
// - data byte sets buffer-full, and address/data flag unless a byte is unread
// - stop leaves address/data flag unchanged
// - clear clock-release bit after ninth falling edge
// - software sets clock-release bit after servicing byte
// - master waits for released clock line
// - any number of data bytes, same sequence
// - detect write collision and receive overflow
// - digitally filter bus inputs before edge detection
// - slave interrupt can wake the core
// - address/data flag: one data, zero address
// - unread byte plus new data byte: overflow, discard
// - transmit write while busy: collision, rejected
`timescale 1ns/1ps
module tws_slave
    import tws_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    tws_if.slave                            bus,
    input  wire logic [tws_pkg::ADDR_W-1:0] own_addr,
    input  wire logic                       stretch_en,
    input  wire logic                       rd_strobe,
    input  wire logic                       sw_release,
    input  wire logic                       tx_wr,
    input  wire logic [tws_pkg::BYTE_W-1:0] tx_data,
    input  wire logic                       clr_wcol,
    input  wire logic                       clr_ovf,
    output logic      [tws_pkg::BYTE_W-1:0] shift_data_reg,
    output logic      [tws_pkg::BYTE_W-1:0] tx_hold,
    output logic                            start_seen_flag,
    output logic                            stop_seen_flag,
    output logic                            buffer_full_flag,
    output logic                            addr_or_data_flag,
    output logic                            receive_overflow_flag,
    output logic                            write_collision_flag,
    output logic                            serial_slave_irq,
    output logic                            clock_release_bit
);
    import tws_pkg::*;

    logic [2:0]        scl_s;
    logic [2:0]        sda_s;
    logic              scl_f;
    logic              sda_f;
    logic              scl_p;
    logic              sda_p;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    tws_sstate_t       state;
    logic [3:0]        cnt;
    logic [BYTE_W-1:0] sh;
    logic              ack_drv;
    logic              in_byte;
    logic              byte_end;
    logic              ack_end;
    logic              addr_hit;
    logic              data_end;

    ////////////////////////////////////////////////////////////////////////
    // three-stage sync; level moves only when stages two and three agree
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], bus.scl};
            sda_s <= {sda_s[1:0], bus.sda};
        end
    end

    // filtered levels and one-cycle history; up to 0.4 us lag fits 400k timing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            if (scl_s[1] == scl_s[2])
                scl_f <= scl_s[2];
            if (sda_s[1] == sda_s[2])
                sda_f <= sda_s[2];
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus events from filtered lines
    assign scl_rise  = scl_f & ~scl_p;
    assign scl_fall  = ~scl_f & scl_p;
    assign start_det = scl_f & scl_p & sda_p & ~sda_f;
    assign stop_det  = scl_f & scl_p & ~sda_p & sda_f;

    // byte slot events; cnt counts rising edges, so cnt 8 marks 8th fall
    assign in_byte  = (state == S_ADDR) || (state == S_DATA);
    assign byte_end = in_byte && scl_fall && (cnt == CNT_BYTE);
    assign ack_end  = in_byte && scl_fall && (cnt == CNT_ACK);
    assign addr_hit = byte_end && (state == S_ADDR) &&
                      (sh[7:1] == own_addr) && (sh[0] == RW_WRITE);
    assign data_end = byte_end && (state == S_DATA);

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencer: address slot, then data slots until stop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_IDLE;
            cnt   <= 4'h0;
            sh    <= BYTE_RST;
        end else if (start_det) begin
            state <= S_ADDR; // repeated start also restarts the address slot
            cnt   <= 4'h0;
        end else if (stop_det) begin
            state <= S_IDLE;
            cnt   <= 4'h0;
        end else begin
            case (state)
                S_ADDR, S_DATA: begin
                    if (scl_rise) begin
                        if (cnt < CNT_BYTE)
                            sh <= {sh[BYTE_W-2:0], sda_f};
                        cnt <= cnt + 4'h1;
                    end
                    if (byte_end && (state == S_ADDR) && !addr_hit)
                        state <= S_SKIP; // foreign address: stay off the bus
                    if (ack_end) begin
                        cnt   <= 4'h0;
                        state <= S_DATA;
                    end
                end
                S_IDLE, S_SKIP: begin
                    cnt <= 4'h0;
                end
                default: begin
                    state <= S_IDLE;
                    cnt   <= 4'h0;
                end
            endcase
        end
    end

    // acknowledge low from 8th to 9th falling edge, also for a lost byte
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            ack_drv <= 1'b0;
        else if (start_det || stop_det || ack_end)
            ack_drv <= 1'b0;
        else if (addr_hit || data_end)
            ack_drv <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // matched address byte always lands in the data register; a data byte lands unless one is unread
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            shift_data_reg <= BYTE_RST;
        else if (addr_hit || (data_end && !buffer_full_flag))
            shift_data_reg <= sh;
    end

    // buffer-full: set wins over the clearing read of the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            buffer_full_flag <= 1'b0;
        else if (addr_hit || data_end)
            buffer_full_flag <= 1'b1;
        else if (rd_strobe)
            buffer_full_flag <= 1'b0;
    end

    // address/data flag; stop leaves it alone
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            addr_or_data_flag <= 1'b0;
        else if (addr_hit)
            addr_or_data_flag <= 1'b0;
        else if (data_end && !buffer_full_flag)
            addr_or_data_flag <= 1'b1;
    end

    // start and stop status bits, each cleared by the other condition
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_seen_flag <= 1'b0;
            stop_seen_flag  <= STOP_RST;
        end else if (start_det) begin
            start_seen_flag <= 1'b1;
            stop_seen_flag  <= 1'b0;
        end else if (stop_det) begin
            start_seen_flag <= 1'b0;
            stop_seen_flag  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error flags: hardware set wins over a software clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            receive_overflow_flag <= 1'b0;
        else if (data_end && buffer_full_flag)
            receive_overflow_flag <= 1'b1;
        else if (clr_ovf)
            receive_overflow_flag <= 1'b0;
    end

    // a transmit write during a transfer is refused and flagged
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            write_collision_flag <= 1'b0;
            tx_hold              <= BYTE_RST;
        end else if (tx_wr && (state != S_IDLE)) begin
            write_collision_flag <= 1'b1;
        end else begin
            if (tx_wr)
                tx_hold <= tx_data;
            if (clr_wcol)
                write_collision_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt pulse only at the 9th fall; no clock gate, so it can wake
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            serial_slave_irq <= 1'b0;
        else
            serial_slave_irq <= ack_end;
    end

    // clock-release bit: a software release beats the hardware clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            clock_release_bit <= RELEASE_RST;
        else if (sw_release || stop_det)
            clock_release_bit <= 1'b1;
        else if (ack_end && stretch_en)
            clock_release_bit <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // open-drain pins: enable low pulls the line low
    assign bus.s_scl_o    = 1'b0;
    assign bus.s_sda_o    = 1'b0;
    assign bus.s_scl_oe_n = clock_release_bit;
    assign bus.s_sda_oe_n = ~ack_drv;
endmodule

// ### hw/tws_master.sv
// two-wire bus master: writes buffered bytes to a slave address
`timescale 1ns/1ps
module tws_master
    import tws_pkg::*;
#(
    parameter int QUARTER = tws_pkg::QUARTER_CYC
)(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    tws_if.master                           bus,
    input  wire logic [tws_pkg::ADDR_W-1:0] tgt_addr,
    input  wire logic                       wr_valid,
    output logic                            wr_ready,
    input  wire logic [tws_pkg::BYTE_W-1:0] wr_data,
    input  wire logic                       wr_last,
    output logic                            busy,
    output logic                            nack
);
    import tws_pkg::*;

    localparam logic [15:0] T_Q = 16'(QUARTER);
    localparam logic [15:0] T_H = 16'(2 * QUARTER);
    localparam logic [15:0] T_B = 16'(4 * QUARTER);

    logic [BYTE_W:0]   mem [2];
    logic              wp;
    logic              rp;
    logic [1:0]        fcnt;
    logic              pop;
    logic [2:0]        scl_s;
    logic [2:0]        sda_s;
    logic              scl_f;
    logic              sda_f;
    tws_mstate_t       state;
    logic [15:0]       tmr;
    logic [3:0]        bitn;
    logic [BYTE_W-1:0] sh;
    logic              last_r;
    logic              scl_oe_n;
    logic              sda_oe_n;
    logic              fetch;
    logic              run;

    ////////////////////////////////////////////////////////////////////////
    // two-entry byte buffer; stretched clock stalls the drain, so it fills
    assign wr_ready = (fcnt != 2'h2);
    assign fetch    = (state == M_BIT) && (bitn == CNT_ACK) && (tmr == 16'h0);
    assign pop      = fetch && (fcnt != 2'h0);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp     <= 1'b0;
            rp     <= 1'b0;
            fcnt   <= 2'h0;
            mem[0] <= '0;
            mem[1] <= '0;
        end else begin
            if (wr_valid && wr_ready) begin
                mem[wp] <= {wr_last, wr_data};
                wp      <= ~wp;
            end
            if (pop)
                rp <= ~rp;
            fcnt <= fcnt + 2'(wr_valid && wr_ready) - 2'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // three-stage sync on the bus lines, same filter as the slave
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
        end else begin
            scl_s <= {scl_s[1:0], bus.scl};
            sda_s <= {sda_s[1:0], bus.sda};
            if (scl_s[1] == scl_s[2])
                scl_f <= scl_s[2];
            if (sda_s[1] == sda_s[2])
                sda_f <= sda_s[2];
        end
    end

    // timer halts while the clock line is held low by the slave
    assign run = (tmr < T_H) || scl_f;

    ////////////////////////////////////////////////////////////////////////
    // bit engine: low half, release, wait for high, high half
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= M_IDLE;
            tmr      <= 16'h0;
            bitn     <= 4'h0;
            sh       <= BYTE_RST;
            last_r   <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
            nack     <= 1'b0;
        end else begin
            case (state)
                M_IDLE: begin
                    tmr <= 16'h0;
                    if ((fcnt != 2'h0) && scl_f && sda_f) begin
                        sda_oe_n <= 1'b0; // start: data falls, clock high
                        nack     <= 1'b0;
                        state    <= M_START;
                    end
                end
                M_START: begin
                    tmr <= tmr + 16'h1;
                    if (tmr == T_H) begin
                        scl_oe_n <= 1'b0;
                        sh       <= {tgt_addr, RW_WRITE};
                        last_r   <= 1'b0;
                        bitn     <= 4'h0;
                        tmr      <= 16'h0;
                        state    <= M_BIT;
                    end
                end
                M_BIT: begin
                    if (fetch) begin
                        if (pop) begin
                            {last_r, sh} <= mem[rp];
                            bitn         <= 4'h0;
                        end
                    end else begin
                        if (run)
                            tmr <= tmr + 16'h1;
                        if (tmr == T_Q)
                            sda_oe_n <= (bitn == CNT_BYTE) ? 1'b1 : sh[BYTE_W-1];
                        if (tmr == T_H)
                            scl_oe_n <= 1'b1;
                        if (tmr == T_B) begin
                            scl_oe_n <= 1'b0;
                            tmr      <= 16'h0;
                            if (bitn < CNT_BYTE) begin
                                sh   <= {sh[BYTE_W-2:0], 1'b0};
                                bitn <= bitn + 4'h1;
                            end else begin
                                nack <= sda_f;
                                if (sda_f || last_r)
                                    state <= M_STOP;
                                else
                                    bitn <= CNT_ACK;
                            end
                        end
                    end
                end
                M_STOP: begin
                    if (run)
                        tmr <= tmr + 16'h1;
                    if (tmr == T_Q)
                        sda_oe_n <= 1'b0;
                    if (tmr == T_H)
                        scl_oe_n <= 1'b1;
                    if (tmr == T_B) begin
                        sda_oe_n <= 1'b1; // stop: data rises, clock high
                        tmr      <= 16'h0;
                        state    <= M_IDLE;
                    end
                end
                default: begin
                    state <= M_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive, open-drain only
    assign bus.m_scl_o    = 1'b0;
    assign bus.m_sda_o    = 1'b0;
    assign bus.m_scl_oe_n = scl_oe_n;
    assign bus.m_sda_oe_n = sda_oe_n;
    assign busy           = (state != M_IDLE);
endmodule

// ### verification/tws_monitor.sv
// assertion checker watching the two-wire bus and the slave status outputs
`timescale 1ns/1ps
module tws_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic s_scl_oe_n,
    input wire logic s_sda_oe_n,
    input wire logic serial_slave_irq,
    input wire logic clock_release_bit,
    input wire logic start_seen_flag,
    input wire logic stop_seen_flag,
    input wire logic addr_or_data_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////
    // bus conditions: data moves while the clock line is high
    sequence start_cond;
        scl && $fell(sda);
    endsequence
    sequence stop_cond;
        scl && $rose(sda);
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    // filter delay plus detection stays well inside eight clocks
    chk_start_flag: assert property (start_cond |-> ##[1:8] start_seen_flag)
        else $error("start flag missing after start condition");
    chk_stop_flag: assert property (stop_cond |-> ##[1:8] stop_seen_flag)
        else $error("stop flag missing after stop condition");
    chk_idle_sda: assert property (stop_seen_flag |-> s_sda_oe_n)
        else $error("slave drives data line while idle");
    chk_irq_pulse: assert property (serial_slave_irq |=> !serial_slave_irq)
        else $error("interrupt wider than one cycle");
    chk_stretch_irq: assert property ($fell(clock_release_bit) |-> serial_slave_irq)
        else $error("clock release cleared without interrupt");
    chk_stretch_hold: assert property (!clock_release_bit |-> !s_scl_oe_n && !scl)
        else $error("clock line not held while release bit low");
    chk_stop_quiet: assert property ($rose(stop_seen_flag) |-> !serial_slave_irq ##1 !serial_slave_irq)
        else $error("interrupt raised by stop");
    chk_stop_keeps_ad: assert property ($rose(stop_seen_flag) |-> $stable(addr_or_data_flag))
        else $error("address data flag changed at stop");
    chk_ack_low: assert property ($changed(s_sda_oe_n) |-> !scl)
        else $error("slave moved data line while clock high");
endmodule

// ### verification/two_wire_slave_receive_path_bench.sv
// self-checking bench: master end writes bytes to the slave end over the bus
`timescale 1ns/1ps
module two_wire_slave_receive_path_bench;
    import tws_pkg::*;
    logic              clk, sys_rst, stretch_en, rd_strobe, sw_release, tx_wr, clr_wcol, clr_ovf;
    logic [ADDR_W-1:0] own_addr, tgt_addr;
    logic [BYTE_W-1:0] tx_data, shift_data_reg, tx_hold, wr_data, first;
    logic              start_seen_flag, stop_seen_flag, buffer_full_flag, addr_or_data_flag;
    logic              receive_overflow_flag, write_collision_flag, serial_slave_irq, clock_release_bit;
    logic              wr_valid, wr_ready, wr_last, busy, nack, svc, saw_full;
    logic [31:0]       seed;
    logic [9:0]        notes[$];
    logic [9:0]        rx_seen;
    int                bad_count, samples_checked;

    tws_if bus_link();
    tws_master #(.QUARTER(5)) u_tws_master (.clk, .sys_rst, .bus(bus_link), .tgt_addr, .wr_valid,
        .wr_ready, .wr_data, .wr_last, .busy, .nack);
    tws_slave u_tws_slave (.clk, .sys_rst, .bus(bus_link), .own_addr, .stretch_en, .rd_strobe,
        .sw_release, .tx_wr, .tx_data, .clr_wcol, .clr_ovf, .shift_data_reg, .tx_hold, .start_seen_flag,
        .stop_seen_flag, .buffer_full_flag, .addr_or_data_flag, .receive_overflow_flag,
        .write_collision_flag, .serial_slave_irq, .clock_release_bit);
    tws_monitor u_tws_monitor (.clk, .sys_rst, .scl(bus_link.scl), .sda(bus_link.sda),
        .s_scl_oe_n(bus_link.s_scl_oe_n), .s_sda_oe_n(bus_link.s_sda_oe_n), .serial_slave_irq,
        .clock_release_bit, .start_seen_flag, .stop_seen_flag, .addr_or_data_flag);

    // what software sees when it services an interrupt
    assign rx_seen = {addr_or_data_flag, buffer_full_flag, shift_data_reg};

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // valid stays up between bytes; dropped only after the last one
    task automatic push(logic [7:0] d, logic last);
        int n;
        n = 0;
        @(negedge clk);
        wr_valid = 1'b1;
        wr_data = d;
        wr_last = last;
        // ready is settled here and cannot move before the taking edge
        while (wr_ready !== 1'b1 && n < 4000) begin
            saw_full = 1'b1;
            n++;
            @(negedge clk);
        end
        if (n == 4000) bad_count++;
        @(posedge clk);
        if (last) begin
            @(negedge clk);
            wr_valid = 1'b0;
        end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (40) @(negedge clk);
        while (busy !== 1'b0 && n < 20000) begin
            n++;
            @(negedge clk);
        end
        if (n == 20000) bad_count++;
        repeat (20) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        results();
    end

    // software side: each interrupt takes the oldest note, then services the byte when svc is set
    initial begin
        forever begin
            @(negedge clk);
            if (serial_slave_irq === 1'b1) begin
                if (notes.size() == 0) check("spurious irq", 10'h001, 10'h000);
                else check("rx byte", rx_seen, notes.pop_front());
                check("release at irq", {9'h000, clock_release_bit}, {9'h000, ~stretch_en});
                if (svc) begin
                    // slow service, so the master really meets a held clock
                    repeat (40) @(negedge clk);
                    rd_strobe = 1'b1;
                    @(negedge clk);
                    rd_strobe = 1'b0;
                    sw_release = 1'b1;
                    @(negedge clk);
                    sw_release = 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {sys_rst, seed} = {1'b1, 32'hE46893A4};
        {stretch_en, rd_strobe, sw_release, tx_wr, clr_wcol, clr_ovf, wr_valid, wr_last} = 8'h00;
        {svc, saw_full, tx_data, wr_data} = 18'h00000;
        own_addr = 7'h00;
        tgt_addr = 7'h00;
        repeat (12) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        check("reset", {2'b00, start_seen_flag, stop_seen_flag, buffer_full_flag, addr_or_data_flag,
            receive_overflow_flag, write_collision_flag, serial_slave_irq, clock_release_bit}, 10'h041);
        repeat (6) @(negedge clk);
        // stretched write of four bytes; master buffer fills while slave holds the clock
        seed = lfsr(seed);
        {own_addr, tgt_addr, stretch_en, svc} = {seed[6:0], seed[6:0], 2'b11};
        notes.push_back({2'b01, own_addr, RW_WRITE});
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            notes.push_back({2'b11, seed[7:0]});
            push(seed[7:0], i == 3);
        end
        wait_idle();
        check("after stop", {2'b00, start_seen_flag, stop_seen_flag, addr_or_data_flag, clock_release_bit,
            receive_overflow_flag, nack, notes.size() == 0, saw_full}, 10'h073);
        // foreign address: no acknowledge, no interrupt; the held byte is retried
        tgt_addr = own_addr ^ 7'h01;
        push(8'hA5, 1'b1);
        for (int n = 0; n < 4000 && nack !== 1'b1; n++) @(negedge clk);
        check("nack", {9'h000, nack}, 10'h001);
        // retry takes the address only after its stop, so it lands here
        tgt_addr = own_addr;
        notes.push_back({2'b01, own_addr, RW_WRITE});
        notes.push_back({2'b11, 8'hA5});
        wait_idle();
        // unstretched, unread: data byte overflows, transmit write collides
        {tgt_addr, stretch_en, svc} = {own_addr, 2'b00};
        seed = lfsr(seed);
        first = seed[7:0];
        tx_data = first;
        tx_wr = 1'b1;
        @(negedge clk);
        tx_wr = 1'b0;
        @(negedge clk);
        check("idle tx", {2'b00, tx_hold}, {2'b00, first});
        notes.push_back({2'b01, own_addr, RW_WRITE});
        notes.push_back({2'b01, own_addr, RW_WRITE});
        push(~first, 1'b1);
        for (int n = 0; n < 200 && start_seen_flag !== 1'b1; n++) @(negedge clk);
        tx_data = ~first;
        tx_wr = 1'b1;
        @(negedge clk);
        tx_wr = 1'b0;
        @(negedge clk);
        check("collision", {1'b0, write_collision_flag, tx_hold}, {2'b01, first});
        wait_idle();
        check("overflow", {8'h00, receive_overflow_flag, buffer_full_flag}, 10'h003);
        {clr_wcol, clr_ovf} = 2'b11;
        @(negedge clk);
        {clr_wcol, clr_ovf} = 2'b00;
        @(negedge clk);
        check("errors cleared", {8'h00, receive_overflow_flag, write_collision_flag}, 10'h000);
        results();
    end
endmodule
